//--- src/hbtc_params.svh
// Constants for the host buffer transfer control block.
// Assumes a Wishbone slave with word index = byte address / 4.
`ifndef HBTC_PARAMS_SVH
`define HBTC_PARAMS_SVH
// Register indices (byte address is four times the index).
`define IDX_STATUS 7'h50
`define IDX_DMA_PERMIT 7'h52
`define IDX_XFER_CTRL 7'h53
`define IDX_BUF_SIZE 7'h54
`define IDX_MODE 7'h58
`define IDX_SRST 7'h59
`define IDX_RPTR_LO 7'h5a
`define IDX_RPTR_HI 7'h5b
`define IDX_WPTR_LO 7'h5c
`define IDX_WPTR_HI 7'h5d
`define IDX_STOP_LO 7'h5e
`define IDX_STOP_HI 7'h5f
// Mode register field positions.
`define MODE_AUTO_WAIT 2
`define MODE_METHOD 3
`define MODE_AUTO_INT 4
`define MODE_NO_AUTO 5
`define MODE_WIDE 6
`define MODE_XT 7
// Transfer control and permit field positions.
`define XC_WR_EN 2
`define XC_RD_EN 3
`define XC_ROP 4
`define XC_DONE 5
`define DP_PERMIT 4
`define DP_CHAN_ON 5
// Reset values.
`define MODE_RST 8'h58
`define SIZE_RST 8'hff
`define STOP_RST 16'h01ff
`define PTR_RST 16'h0000
`endif

//--- src/hbtc_pkg.sv
// Types for the host buffer transfer control block.
// Assumes hbtc_params.svh supplies the numeric constants.
package hbtc_pkg;
  // Host access sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_MOVE = 2'b11,
    S_HOLD = 2'b10
  } fsm_t;
  // Buffer memory request toward the RAM.
  typedef struct packed {
    logic stb;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } buf_req_t;
  // Whole state of the block except the HOST_DATA_O read data register.
  typedef struct packed {
    logic [7:0] mode;
    logic srst;
    logic [15:0] rptr;
    logic [15:0] wptr;
    logic [15:0] stop;
    logic wr_en;
    logic rd_en;
    logic rop;
    logic done;
    logic permit;
    logic [7:0] size;
    logic hint;
    logic ack;
    logic [7:0] rdat;
    fsm_t fsm;
    logic [2:0] cnt;
    logic [2:0] acc_s;
    logic [2:0] dack_s;
    logic [2:0] fix_s;
    logic acc_st;
    logic dack_st;
    logic fix_st;
    buf_req_t breq;
    logic [15:0] hdo;
    logic hoe;
  } st_t;
endpackage

//--- src/host_buffer_transfer_control.sv
// Host buffer transfer control: host port sequencing, buffer pointers,
// stop-pointer match and the microcontroller register file.
// Assumes a classic Wishbone master on CLK and a buffer RAM that returns
// read data in the cycle of its strobe; BUF_READY says it can take a request.
// Limitation: a buffer move is not held off by BUF_READY once the sequencer
// has left the wait state, so the RAM must not drop ready mid-request.
`include "hbtc_params.svh"

module host_buffer_transfer_control (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [8:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic HOST_STROBE,
  input wire logic HOST_DACK_N,
  input wire logic HOST_FIXED_DMA_BIT,
  input wire logic HOST_AUTO_CMD,
  input wire logic [15:0] HOST_DATA_I,
  output logic [15:0] HOST_DATA_O,
  output logic HOST_DATA_OE,
  output logic HOST_READY,
  output logic HOST_DREQ,
  output logic HOST_INT,
  output logic XT_MODE,
  output logic WIDE_MODE,
  output logic AUTO_CMD_INHIBIT,
  output logic BUF_STB,
  output logic BUF_WR,
  output logic [15:0] BUF_ADDR,
  output logic [15:0] BUF_WDATA,
  input wire logic [15:0] BUF_RDATA,
  input wire logic BUF_READY
);

  // All state but HOST_DATA_O lives in one packed struct: r is the register, n its next value.
  hbtc_pkg::st_t r; // Registered state.
  hbtc_pkg::st_t n; // Next state.

  // Decoded bus request, taken in the cycle before ack rises.
  logic req;
  // Register index from the byte address.
  logic [6:0] idx;
  // Byte write strobe; only the low lane carries register data.
  logic wr8;
  // Low byte of the write data.
  logic [7:0] wd;
  // Mode decode.
  // XT interface selected.
  logic xt;
  // Programmed I/O transfer in use; XT is always programmed I/O.
  logic pio;
  // Sixteen-bit host data, AT only.
  logic wide;
  // A host transfer is enabled and not yet done.
  logic active;
  // The DMA channel is open, either by itself or through the host gate.
  logic dma_ok;
  // The host is asking for a data move this cycle.
  logic host_req;
  // The pending host access may really move data.
  logic xfer_ok;
  // Automatic wait while the buffer cannot take a request.
  logic stall;
  // Active buffer pointer for the current direction.
  logic [15:0] ptr;
  // Pointer increment, one byte or one word.
  logic [15:0] step;
  // High-byte compare mask from the buffer size register.
  logic [7:0] hmask;
  // The active pointer has reached the stop pointer.
  logic hit;
  // A host auto command that is allowed to run.
  logic auto_go;

  // Masked comparison of a pointer with the stop pointer.
  // The low byte is always compared in full; only the high byte is masked,
  // so a small buffer still stops on an exact byte.
  function automatic logic match(input logic [15:0] p, input logic [15:0] s,
                                 input logic [7:0] m);
    match = (p[7:0] == s[7:0]) && (((p[15:8] ^ s[15:8]) & m) == 8'h00);
  endfunction

  // Combinational decode used by the next-state process.
  // It reads registered state and pins only, never the next state.
  always_comb begin
    req = WB_CYC_I && WB_STB_I && !r.ack;
    idx = WB_ADR_I[8:2];
    wr8 = req && WB_WE_I && WB_SEL_I[0];
    wd = WB_DAT_I[7:0];
    xt = r.mode[`MODE_XT];
    pio = xt || r.mode[`MODE_METHOD];
    wide = !xt && r.mode[`MODE_WIDE];
    // Soft reset and a finished transfer both refuse host moves.
    active = (r.wr_en || r.rd_en) && !r.done && !r.srst;
    // A set permit hands the channel gate to the host.
    dma_ok = !pio && (!r.permit || r.fix_st);
    // DMA may be answered by acknowledge or by a PIO access.
    host_req = r.acc_st || (!pio && r.dack_st);
    xfer_ok = active && (pio ? r.acc_st : dma_ok);
    stall = r.mode[`MODE_AUTO_WAIT] && !BUF_READY;
    // The read enable wins if software sets both enables.
    ptr = r.rd_en ? r.rptr : r.wptr;
    step = wide ? 16'h0002 : 16'h0001;
    // Bit 0 of the size register is the interrupt reset enable, so the
    // lowest high-byte bit is always compared.
    hmask = {r.size[7:1], 1'b1};
    hit = match(ptr, r.stop, hmask) ||
          (wide && match(ptr + 16'h0001, r.stop, hmask));
    // Automatic command runs only in AT mode, out of soft reset.
    auto_go = HOST_AUTO_CMD && !xt && !r.mode[`MODE_NO_AUTO] && !r.srst;
  end

  // Next state: bus slave, host sequencer, pointers and flags.
  // Later sections override earlier ones, so the order sets priority:
  // a register write beats a hardware clear, an auto command beats a register
  // write, and the reset register beats everything.
  always_comb begin
    n = r;
    n.ack = req;
    n.breq.stb = 1'b0;
    // Three-stage synchronisers; a level counts once stages 2 and 3 agree.
    // The host pins are asynchronous to CLK; the agreement test also filters
    // a one-cycle glitch that a plain two-stage synchroniser would pass on.
    n.acc_s = {r.acc_s[1:0], HOST_STROBE};
    n.dack_s = {r.dack_s[1:0], !HOST_DACK_N};
    n.fix_s = {r.fix_s[1:0], HOST_FIXED_DMA_BIT};
    if (r.acc_s[1] == r.acc_s[2]) begin
      n.acc_st = r.acc_s[2];
    end
    if (r.dack_s[1] == r.dack_s[2]) begin
      n.dack_st = r.dack_s[2];
    end
    if (r.fix_s[1] == r.fix_s[2]) begin
      n.fix_st = r.fix_s[2];
    end

    // Read mux; unmapped addresses read as zero and still ack.
    // The data is registered here so WB_DAT_O stands until the next request.
    if (req) begin
      case (idx)
        `IDX_STATUS: n.rdat = {7'h00, r.done};
        `IDX_DMA_PERMIT: n.rdat = {2'b00, r.fix_st, r.permit, 4'h0};
        `IDX_XFER_CTRL: n.rdat = {2'b00, r.done, r.rop, r.rd_en, r.wr_en, 2'b00};
        `IDX_BUF_SIZE: n.rdat = r.size;
        `IDX_MODE: n.rdat = r.mode;
        `IDX_SRST: n.rdat = {7'h00, r.srst};
        `IDX_RPTR_LO: n.rdat = r.rptr[7:0];
        `IDX_RPTR_HI: n.rdat = r.rptr[15:8];
        `IDX_WPTR_LO: n.rdat = r.wptr[7:0];
        `IDX_WPTR_HI: n.rdat = r.wptr[15:8];
        `IDX_STOP_LO: n.rdat = r.stop[7:0];
        `IDX_STOP_HI: n.rdat = r.stop[15:8];
        default: n.rdat = 8'h00;
      endcase
    end

    // Host access sequencer.
    // IDLE waits for an access, WAIT holds ready low, MOVE runs one buffer
    // cycle and HOLD waits for the host to end the access.
    case (r.fsm)
      hbtc_pkg::S_IDLE: begin
        n.hoe = 1'b0;
        if (host_req) begin
          // Field 01..11 loads 1..3, which gives 2..4 wait cycles, the top of
          // each range. Field 00 loads zero.
          n.cnt = {1'b0, r.mode[1:0]};
          if (xfer_ok && (!r.acc_st || ((r.mode[1:0] == 2'b00) && !stall))) begin
            // A DMA acknowledge never waits, and field 00 skips the wait state
            // unless the buffer is busy.
            n.fsm = hbtc_pkg::S_MOVE;
          end else begin
            // An access that cannot move data is let through without waits.
            n.fsm = xfer_ok ? hbtc_pkg::S_WAIT : hbtc_pkg::S_HOLD;
          end
        end
      end
      hbtc_pkg::S_WAIT: begin
        // Count the programmed waits first, then any automatic ones.
        if (r.cnt != 3'd0) begin
          n.cnt = r.cnt - 3'd1;
        end else if (!stall) begin
          n.fsm = hbtc_pkg::S_MOVE;
        end
      end
      hbtc_pkg::S_MOVE: begin
        // One buffer cycle: the word or byte moves and the pointer steps.
        // The strobe is issued even if the buffer drops ready here; see the
        // limitation in the file header.
        n.breq.stb = 1'b1;
        n.breq.wr = r.wr_en && !r.rd_en;
        n.breq.addr = ptr;
        n.breq.wdata = wide ? HOST_DATA_I : {8'h00, HOST_DATA_I[7:0]};
        if (r.rd_en) begin
          n.rptr = r.rptr + step;
          n.hoe = 1'b1;
        end else begin
          n.wptr = r.wptr + step;
        end
        // The pointer lands one beyond the stop value, or two beyond when a wide move matches on its first byte.
        if (hit) begin
          n.done = 1'b1;
        end
        if (r.size[0]) begin
          n.hint = 1'b0;
        end
        n.fsm = hbtc_pkg::S_HOLD;
      end
      hbtc_pkg::S_HOLD: begin
        // Wait for the host to end its strobe before the next access.
        // This also keeps a long strobe from moving a second byte.
        if (!host_req) begin
          n.fsm = hbtc_pkg::S_IDLE;
        end
      end
      default: n.fsm = hbtc_pkg::S_IDLE;
    endcase

    // Register writes from the microcontroller.
    // Only the low byte lane is decoded; a write with SEL[0] low is still
    // acknowledged and changes nothing unless it hits the reset register, which
    // still clears state. Read-only bits ignore writes.
    if (wr8) begin
      case (idx)
        `IDX_DMA_PERMIT: n.permit = wd[`DP_PERMIT];
        `IDX_XFER_CTRL: begin
          n.wr_en = wd[`XC_WR_EN];
          n.rd_en = wd[`XC_RD_EN];
          n.rop = wd[`XC_ROP];
          // A fresh enable raises the host interrupt.
          if (r.mode[`MODE_AUTO_INT] && !xt &&
              ((wd[`XC_WR_EN] && !r.wr_en) || (wd[`XC_RD_EN] && !r.rd_en))) begin
            n.hint = 1'b1;
          end
        end
        `IDX_BUF_SIZE: n.size = wd;
        `IDX_MODE: n.mode = wd;
        `IDX_RPTR_LO: n.rptr[7:0] = wd;
        `IDX_RPTR_HI: n.rptr[15:8] = wd;
        `IDX_WPTR_LO: n.wptr[7:0] = wd;
        `IDX_WPTR_HI: n.wptr[15:8] = wd;
        `IDX_STOP_LO: n.stop[7:0] = wd;
        `IDX_STOP_HI: begin
          n.stop[15:8] = wd;
          // With an enable still set this starts a new transfer cycle, but a
          // match landing in the same cycle keeps done set.
          if (r.wr_en || r.rd_en) begin
            n.done = (r.fsm == hbtc_pkg::S_MOVE) && hit;
            if (r.mode[`MODE_AUTO_INT] && !xt) begin
              n.hint = 1'b1;
            end
          end
        end
        default: n.rptr = n.rptr;
      endcase
    end

    // Automatic host command: write pointer to zero, stop to 01FF.
    // It clears done even when a match lands in the same cycle, since the
    // command starts a fresh transfer from the bottom of the buffer.
    if (auto_go) begin
      n.wptr = `PTR_RST;
      n.stop = `STOP_RST;
      n.wr_en = 1'b1;
      n.rd_en = 1'b0;
      n.rop = 1'b0;
      n.done = 1'b0;
      if (r.mode[`MODE_AUTO_INT]) begin
        n.hint = 1'b1;
      end
    end

    // Any write to the reset register, or a held soft-reset bit, clears
    // the buffer and host state and aborts the host operation.
    // Mode and buffer size survive it; only power-on reset sets those.
    if (wr8 && idx == `IDX_SRST) begin
      n.srst = wd[0];
    end
    if ((req && WB_WE_I && idx == `IDX_SRST) || r.srst) begin
      n.rptr = `PTR_RST;
      n.wptr = `PTR_RST;
      n.stop = `STOP_RST;
      n.done = 1'b0;
      n.wr_en = 1'b0;
      n.rd_en = 1'b0;
      n.rop = 1'b0;
      n.permit = 1'b0;
      n.hint = 1'b0;
      n.hoe = 1'b0;
      n.breq.stb = 1'b0;
      n.fsm = hbtc_pkg::S_IDLE;
    end
  end

  // State register; power-on values are constants only.
  // Fields without a listed reset value start at zero through the blanket
  // clear, which keeps the reset branch to constants.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r <= '0;
      r.mode <= `MODE_RST;
      r.srst <= 1'b1;
      r.stop <= `STOP_RST;
      r.size <= `SIZE_RST;
      r.fsm <= hbtc_pkg::S_IDLE;
    end else begin
      r <= n;
    end
  end

  // Ready falls only while a selected access waits or stalls.
  // It is combinational so the host sees the wait in the same cycle as the
  // state that causes it; a DMA acknowledge never pulls it low.
  assign HOST_READY = !((r.fsm == hbtc_pkg::S_WAIT) ||
                        ((r.fsm == hbtc_pkg::S_MOVE) && stall && r.acc_st));
  // DMA request only in AT DMA mode with the channel gated on.
  // It drops while an access is in flight so one request gives one move.
  assign HOST_DREQ = !pio && active && dma_ok && (r.fsm == hbtc_pkg::S_IDLE);
  // Interrupt and mode outputs are copies of registered state; WIDE_MODE is also forced low in XT mode.
  assign HOST_INT = r.hint;
  assign XT_MODE = xt;
  assign WIDE_MODE = wide;
  assign AUTO_CMD_INHIBIT = r.mode[`MODE_NO_AUTO];
  // Buffer request, all fields registered in the MOVE cycle.
  assign BUF_STB = r.breq.stb;
  assign BUF_WR = r.breq.wr;
  assign BUF_ADDR = r.breq.addr;
  assign BUF_WDATA = r.breq.wdata;
  assign HOST_DATA_OE = r.hoe;
  assign WB_ACK_O = r.ack;
  assign WB_DAT_O = {24'h00_0000, r.rdat};

  // Read data for the host is captured one cycle after the buffer strobe.
  // The buffer answers in the strobe cycle, so the capture edge is the one
  // that ends it; narrow transfers clear the upper byte.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HOST_DATA_O <= 16'h0000;
    end else if (r.breq.stb && !r.breq.wr) begin
      HOST_DATA_O <= wide ? BUF_RDATA : {8'h00, BUF_RDATA[7:0]};
    end
  end

endmodule

//--- dv/hbtc_sva.sv
// Port checker for the host buffer transfer control block.
// Bound to the design top; it sees that module's ports only.
module hbtc_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [8:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic HOST_STROBE,
  input wire logic HOST_DACK_N,
  input wire logic HOST_READY,
  input wire logic HOST_INT,
  input wire logic XT_MODE,
  input wire logic WIDE_MODE,
  input wire logic AUTO_CMD_INHIBIT,
  input wire logic BUF_STB
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // A register write first seen at this edge.
  logic wr_go;
  logic [6:0] idx;
  assign idx = WB_ADR_I[8:2];
  assign wr_go = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] && !WB_ACK_O;
  ack_resp_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus request not acknowledged");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  dat_upper_a: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == '0)
    else $error("read data upper bits not zero");
  mode_out_a: assert property (wr_go && idx == 7'h58 |=>
    {XT_MODE, WIDE_MODE, AUTO_CMD_INHIBIT} == $past(WB_DAT_I[7:5]))
    else $error("mode outputs do not follow mode write");
  srst_write_a: assert property (wr_go && idx == 7'h59 |=> !HOST_INT && HOST_READY)
    else $error("reset write left interrupt or wait");
  ready_cause_a: assert property (!HOST_READY |-> HOST_STROBE || !HOST_DACK_N)
    else $error("ready low with no host access");
  move_delay_a: assert property (BUF_STB |-> $past(HOST_STROBE, 4) || !$past(HOST_DACK_N, 4))
    else $error("buffer move too soon after access");
  buf_pulse_a: assert property (BUF_STB |=> !BUF_STB)
    else $error("buffer strobe longer than one cycle");
endmodule

bind host_buffer_transfer_control hbtc_sva chk (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
  .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .HOST_STROBE, .HOST_DACK_N,
  .HOST_READY, .HOST_INT, .XT_MODE, .WIDE_MODE, .AUTO_CMD_INHIBIT, .BUF_STB);

//--- dv/host_bus_model.sv
// Host bus stand-in that makes data accesses and DMA acknowledges.
// Assumes access() is called just after a rising edge of CLK.
module host_bus_model (
  input wire logic CLK,
  input wire logic HOST_READY,
  output logic HOST_STROBE,
  output logic HOST_DACK_N,
  output logic [15:0] HOST_DATA_I
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    HOST_STROBE = 1'b0;
    HOST_DACK_N = 1'b1;
    HOST_DATA_I = 16'h0000;
  end
  // A request is answered by a data access here, or by an acknowledge below.
  // The strobe is held well past the release of ready, so waits are counted.
  task automatic access(input logic [15:0] d, output int waits);
    waits = 0;
    HOST_STROBE <= 1'b1;
    HOST_DATA_I <= d;
    repeat (30) begin
      @(posedge CLK);
      if (HOST_READY !== 1'b1) waits++;
    end
    HOST_STROBE <= 1'b0;
    // Released data is inverted so a stale value never looks valid.
    HOST_DATA_I <= ~d;
    repeat (6) @(posedge CLK);
  endtask
  // A DMA acknowledge cycle, held and released like a data access.
  task automatic dack(input logic [15:0] d, output int waits);
    waits = 0;
    HOST_DACK_N <= 1'b0;
    HOST_DATA_I <= d;
    repeat (30) begin
      @(posedge CLK);
      if (HOST_READY !== 1'b1) waits++;
    end
    HOST_DACK_N <= 1'b1;
    HOST_DATA_I <= ~d;
    repeat (6) @(posedge CLK);
  endtask
endmodule

//--- dv/tb_host_buffer_transfer_control.sv
// Testbench for the host buffer transfer control block.
// Assumes hbtc_sva binds itself and host_bus_model drives the host port.
module tb_host_buffer_transfer_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0, BUF_READY = 1;
  logic [8:0] WB_ADR_I = '0;
  logic [3:0] WB_SEL_I = 4'hf;
  logic [31:0] WB_DAT_I = '0, WB_DAT_O;
  logic WB_ACK_O, HOST_STROBE, HOST_FIXED_DMA_BIT = 0, HOST_AUTO_CMD = 0, BUF_STB;
  logic HOST_DACK_N, HOST_DATA_OE, oe_seen = 0;
  logic HOST_READY, HOST_DREQ, HOST_INT, XT_MODE, WIDE_MODE, AUTO_CMD_INHIBIT;
  logic [15:0] HOST_DATA_I, HOST_DATA_O, BUF_ADDR, BUF_WDATA, BUF_RDATA, b_addr, b_dat;
  int checked = 0, n_mismatch = 0, moves = 0, w;
  logic [7:0] q;
  logic [6:0] ix [9] = '{7'h58, 7'h59, 7'h5a, 7'h5b, 7'h5c, 7'h5d, 7'h5e, 7'h5f, 7'h10};
  logic [7:0] ex [9] = '{8'h58, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h01, 8'h00};
  always #10 CLK = ~CLK;
  host_buffer_transfer_control dut (.CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
    .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .HOST_STROBE, .HOST_DACK_N,
    .HOST_FIXED_DMA_BIT, .HOST_AUTO_CMD, .HOST_DATA_I, .HOST_DATA_O, .HOST_DATA_OE,
    .HOST_READY, .HOST_DREQ, .HOST_INT, .XT_MODE, .WIDE_MODE, .AUTO_CMD_INHIBIT, .BUF_STB,
    .BUF_WR(), .BUF_ADDR, .BUF_WDATA, .BUF_RDATA, .BUF_READY);
  host_bus_model host (.CLK, .HOST_READY, .HOST_STROBE, .HOST_DACK_N, .HOST_DATA_I);
  // Buffer memory stand-in: read data answers the address in the strobe cycle,
  // and each move is counted with its address and data kept; any driven host data cycle sets a sticky flag.
  assign BUF_RDATA = ~BUF_ADDR;
  always @(posedge CLK) begin
    if (HOST_DATA_OE === 1'b1) oe_seen <= 1'b1;
    if (BUF_STB === 1'b1) begin
      moves <= moves + 1;
      b_addr <= BUF_ADDR;
      b_dat <= BUF_WDATA;
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle; read data is taken at the acknowledging edge.
  task automatic wb(input logic we, input logic [6:0] i, input logic [7:0] d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= {i, 2'b00};
    WB_DAT_I <= {24'h0, d};
    do @(posedge CLK); while (WB_ACK_O !== 1'b1);
    q = WB_DAT_O[7:0];
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    check({8'h00, q}, {8'h00, e});
  endtask
  task automatic pulse_cmd;
    HOST_AUTO_CMD <= 1'b1;
    @(posedge CLK);
    HOST_AUTO_CMD <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    for (int k = 0; k < 9; k++) rd(ix[k], ex[k]);
    wb(1'b1, 7'h53, 8'h04);
    host.access(16'h1234, w);
    check(16'(moves + w), 16'h0000);
    wb(1'b1, 7'h59, 8'h00);
    wb(1'b1, 7'h58, 8'h5b);
    wb(1'b1, 7'h5c, 8'hfe);
    wb(1'b1, 7'h5f, 8'h00);
    wb(1'b1, 7'h5e, 8'hff);
    wb(1'b1, 7'h53, 8'h04);
    check(HOST_INT, 16'h0001);
    host.access(16'hbeef, w);
    check(16'(w >= 3 && w <= 4), 16'h0001);
    check(b_addr, 16'h00fe);
    check(b_dat, 16'hbeef);
    rd(7'h53, 8'h24);
    rd(7'h50, 8'h01);
    rd(7'h5c, 8'h00);
    rd(7'h5d, 8'h01);
    host.access(16'h5555, w);
    check(16'(moves), 16'h0001);
    wb(1'b1, 7'h58, 8'h5c);
    wb(1'b1, 7'h5f, 8'h01);
    rd(7'h50, 8'h00);
    BUF_READY <= 1'b0;
    fork
      begin
        repeat (12) @(posedge CLK);
        BUF_READY <= 1'b1;
      end
    join_none
    host.access(16'h0f0f, w);
    check(16'(w >= 6), 16'h0001);
    check(b_addr, 16'h0100);
    wb(1'b1, 7'h59, 8'h00);
    rd(7'h5d, 8'h00);
    rd(7'h5f, 8'h01);
    rd(7'h5e, 8'hff);
    wb(1'b1, 7'h5a, 8'h34);
    wb(1'b1, 7'h53, 8'h18);
    host.access(16'h0000, w);
    check(b_addr, 16'h0034);
    check(HOST_DATA_O, 16'hffcb);
    check(oe_seen, 16'h0001);
    rd(7'h5a, 8'h36);
    wb(1'b1, 7'h5c, 8'h12);
    pulse_cmd();
    rd(7'h5c, 8'h00);
    rd(7'h5e, 8'hff);
    rd(7'h53, 8'h04);
    wb(1'b1, 7'h58, 8'h7c);
    wb(1'b1, 7'h5c, 8'h12);
    pulse_cmd();
    rd(7'h5c, 8'h12);
    wb(1'b1, 7'h58, 8'h50);
    wb(1'b1, 7'h52, 8'h10);
    HOST_FIXED_DMA_BIT <= 1'b1;
    repeat (5) @(posedge CLK);
    rd(7'h52, 8'h30);
    check(HOST_DREQ, 16'h0001);
    host.dack(16'h4321, w);
    check(16'(w), 16'h0000);
    check(b_addr, 16'h0012);
    check(b_dat, 16'h4321);
    wb(1'b1, 7'h58, 8'h80);
    check({XT_MODE, WIDE_MODE}, 16'h0002);
    summarize();
  end
  // Cuts a hang short well after the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge CLK);
    n_mismatch++;
    summarize();
  end
endmodule
